/* design/mtd_event_detector.sv */
/*
 * Significant motion and relative tilt event detector with pin routing,
 * status flags and pulsed or latched interrupt behaviour.
 * Assumes all inputs come from logic on mclk_i (register file, pedometer core
 * and accelerometer data path); acceleration samples are held between updates.
 */
module mtd_event_detector
   import mtd_pkg::*;
#(
   parameter int unsigned ACC_W       = 16,
   parameter int unsigned TICK_CYCLES = EVAL_PERIOD_CYC
) (
   // Clock and reset.
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   // Control bits.
   input  wire logic             embedded_functions_on_i,
   input  wire logic             sigmove_enable_i,
   input  wire logic             incline_enable_i,
   input  wire logic             latch_events_i,
   input  wire logic             sigmove_route_pin_a_i,
   input  wire logic             incline_route_pin_a_i,
   input  wire logic             incline_route_pin_b_i,
   // Threshold register access.
   input  wire logic             bank_access_bit_i,
   input  wire logic             thr_wr_i,
   input  wire logic [7:0]       thr_wdata_i,
   output logic      [7:0]       thr_rdata_o,
   // Event source register read strobe.
   input  wire logic             event_src_rd_i,
   // Pedometer core.
   input  wire logic             step_detected_i,
   input  wire logic             debounce_active_i,
   input  wire logic [2:0]       debounce_step_count_i,
   // Accelerometer sample.
   input  wire logic [ACC_W-1:0] acc_x_i,
   input  wire logic [ACC_W-1:0] acc_y_i,
   input  wire logic [ACC_W-1:0] acc_z_i,
   // Status flags and interrupt pins.
   output logic                  sigmove_event_flag_o,
   output logic                  incline_event_flag_o,
   output logic                  irq_pin_a_o,
   output logic                  irq_pin_b_o
);

   localparam int unsigned DW = 2 * ACC_W + 2;
   localparam int unsigned PW = 2 * DW + COS2_SHIFT;

   // Values that the counters, the angle compare or the routing tables cannot serve are refused.
   if (ACC_W < 4 || ACC_W > 24) begin : g_chk_acc
      $error("ACC_W must lie between 4 and 24");
   end
   if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << TICK_W)) begin : g_chk_tick
      $error("TICK_CYCLES out of range for the tick counter");
   end
   if (PIN_PULSE_CYC < 1 || PIN_PULSE_CYC >= (1 << PULSE_W)) begin : g_chk_pulse
      $error("PIN_PULSE_CYC does not fit the pin pulse counter");
   end
   if (TILT_HOLD_TICKS < 1 || TILT_HOLD_TICKS > (1 << HOLD_W)) begin : g_chk_hold
      $error("TILT_HOLD_TICKS does not fit the hold counter");
   end
   if (COS2_NUM == 0 || COS2_NUM >= (1 << COS2_SHIFT)) begin : g_chk_angle
      $error("COS2_NUM must be a fraction below one");
   end
   if (EV_N != 2) begin : g_chk_events
      $error("The routing tables are built for two events");
   end

   typedef struct packed {
      logic [TICK_W-1:0]           tick_cnt_q;
      logic                        tick_q;
      logic [7:0]                  thr_q;
      logic [7:0]                  thr_rdata_q;
      logic [7:0]                  step_cnt_q;
      logic                        tilt_run_q;
      logic                        tilt_first_q;
      logic [HOLD_W-1:0]           hold_cnt_q;
      logic [ACC_W-1:0]            start_x_q;
      logic [ACC_W-1:0]            start_y_q;
      logic [ACC_W-1:0]            start_z_q;
      logic [EV_N-1:0]             lat_q;
      logic [EV_N-1:0]             sflag_q;
      logic [EV_N-1:0][PULSE_W-1:0] pcnt_q;
      logic [EV_N-1:0]             flag_out_q;
      logic                        pin_a_q;
      logic                        pin_b_q;
   } mtd_state_t;

   mtd_state_t s_q;
   mtd_state_t s_d;

   // Debounce raises the threshold when it is the larger of the two.
   function automatic logic [7:0] mtd_eff_thr(input logic [7:0] thr, input logic deb_on,
                                              input logic [2:0] deb);
      logic [7:0] deb_w;
      deb_w = {5'h00, deb};
      if (deb_on && thr < deb_w) begin
         return deb_w;
      end
      return thr;
   endfunction : mtd_eff_thr

   // True when the angle between two vectors exceeds the tilt limit. Squares are
   // compared to avoid a root; a non-positive dot product is 90 degrees or more.
   function automatic logic mtd_angle_over(input logic signed [ACC_W-1:0] ax,
                                           input logic signed [ACC_W-1:0] ay,
                                           input logic signed [ACC_W-1:0] az,
                                           input logic signed [ACC_W-1:0] bx,
                                           input logic signed [ACC_W-1:0] by,
                                           input logic signed [ACC_W-1:0] bz);
      logic signed [DW-1:0] dot;
      logic signed [DW-1:0] na;
      logic signed [DW-1:0] nb;
      logic [PW-1:0]        lhs;
      logic [PW-1:0]        rhs;
      dot = DW'(ax) * DW'(bx) + DW'(ay) * DW'(by) + DW'(az) * DW'(bz);
      na  = DW'(ax) * DW'(ax) + DW'(ay) * DW'(ay) + DW'(az) * DW'(az);
      nb  = DW'(bx) * DW'(bx) + DW'(by) * DW'(by) + DW'(bz) * DW'(bz);
      if (dot <= 0) begin
         return 1'b1;
      end
      lhs = (PW'($unsigned(dot)) * PW'($unsigned(dot))) << COS2_SHIFT;
      rhs = PW'(COS2_NUM) * PW'($unsigned(na)) * PW'($unsigned(nb));
      return lhs < rhs;
   endfunction : mtd_angle_over

   // A latched event holds its pin until read; otherwise the pin follows the
   // short pulse counter, so a slow host can miss an unlatched event.
   function automatic logic mtd_pin_level(input logic [EV_N-1:0] route,
                                          input logic [EV_N-1:0] held,
                                          input logic [EV_N-1:0] lat,
                                          input logic [EV_N-1:0] pulse_on);
      logic lvl;
      lvl = 1'b0;
      for (int i = 0; i < EV_N; i++) begin
         if (held[i]) begin
            lvl = lvl | (route[i] & lat[i]);
         end else begin
            lvl = lvl | (route[i] & pulse_on[i]);
         end
      end
      return lvl;
   endfunction : mtd_pin_level

   logic [EV_N-1:0] route_a;
   logic [EV_N-1:0] route_b;
   logic [EV_N-1:0] ev;
   logic [EV_N-1:0] hold_mode;
   logic            sig_on;
   logic            tilt_on;
   logic            over;
   logic [7:0]      eff;

   logic            tick_wrap;
   logic [EV_N-1:0] held_off;
   logic [EV_N-1:0] pulsing;
   logic            sig_eval;
   logic            sig_hit;
   logic            tilt_eval;
   logic            hold_done;

   always_comb begin
      route_a                = '0;
      route_b                = '0;
      route_a[EV_SIGMOVE]    = sigmove_route_pin_a_i;
      route_a[EV_INCLINE]    = incline_route_pin_a_i;
      route_b[EV_INCLINE]    = incline_route_pin_b_i;
      // Latching needs a pin; an unrouted event keeps the short status pulse.
      hold_mode              = {EV_N{latch_events_i}} & (route_a | route_b);
      sig_on                 = embedded_functions_on_i & sigmove_enable_i;
      tilt_on                = embedded_functions_on_i & incline_enable_i;
      eff                    = mtd_eff_thr(s_q.thr_q, debounce_active_i, debounce_step_count_i);
      over                   = mtd_angle_over(acc_x_i, acc_y_i, acc_z_i,
                                              s_q.start_x_q, s_q.start_y_q, s_q.start_z_q);
      ev                     = '0;
      s_d                    = s_q;

      // Each detector is gated by its enables and by a latched event still pending.
      tick_wrap = (s_q.tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
      held_off  = hold_mode & s_q.lat_q;
      sig_eval  = sig_on & step_detected_i & ~held_off[EV_SIGMOVE];
      sig_hit   = ({1'b0, s_q.step_cnt_q} + 9'h001) >= {1'b0, eff};
      tilt_eval = tilt_on & s_q.tick_q & ~held_off[EV_INCLINE];
      hold_done = s_q.hold_cnt_q == HOLD_W'(TILT_HOLD_TICKS - 1);
      pulsing   = '0;

      // Evaluation tick at the embedded rate.
      // The tick runs free, so an event can land anywhere inside a status period.
      s_d.tick_q = 1'b0;
      if (tick_wrap) begin
         s_d.tick_cnt_q = '0;
         s_d.tick_q     = 1'b1;
      end else begin
         s_d.tick_cnt_q = s_q.tick_cnt_q + 1'b1;
      end

      // Threshold register, visible only through the open bank.
      // A closed bank reads as zero, so software can see that the bank is shut.
      if (bank_access_bit_i && thr_wr_i) begin
         s_d.thr_q = thr_wdata_i;
      end
      s_d.thr_rdata_q = bank_access_bit_i ? s_d.thr_q : 8'h00;

      // Significant motion step accumulation.
      // Steps are ignored while a latched event waits, so none is counted twice.
      if (!sig_on) begin
         s_d.step_cnt_q = '0;
      end else if (sig_eval) begin
         if (sig_hit) begin
            ev[EV_SIGMOVE] = 1'b1;
            s_d.step_cnt_q = '0;
         end else begin
            s_d.step_cnt_q = s_q.step_cnt_q + 8'h01;
         end
      end

      // Relative tilt with a moving start position.
      s_d.tilt_run_q = tilt_on;
      if (tilt_on && !s_q.tilt_run_q) begin
         s_d.start_x_q    = acc_x_i;
         s_d.start_y_q    = acc_y_i;
         s_d.start_z_q    = acc_z_i;
         s_d.tilt_first_q = 1'b1;
         s_d.hold_cnt_q   = '0;
      end else if (tilt_eval) begin
         // One quiet tick restarts the hold, so the first event needs unbroken excess.
         if (!over) begin
            s_d.hold_cnt_q = '0;
         end else if (!s_q.tilt_first_q || hold_done) begin
            ev[EV_INCLINE]   = 1'b1;
            s_d.tilt_first_q = 1'b0;
            s_d.hold_cnt_q   = '0;
            s_d.start_x_q    = acc_x_i;
            s_d.start_y_q    = acc_y_i;
            s_d.start_z_q    = acc_z_i;
         end else begin
            s_d.hold_cnt_q = s_q.hold_cnt_q + 1'b1;
         end
      end

      // Per-event flag and pin behaviour.
      // A set wins over a clear in one cycle, so an event racing a read is kept.
      for (int i = 0; i < EV_N; i++) begin
         if (ev[i]) begin
            s_d.lat_q[i] = 1'b1;
         end else if (event_src_rd_i || !hold_mode[i]) begin
            s_d.lat_q[i] = 1'b0;
         end
         if (ev[i]) begin
            s_d.sflag_q[i] = 1'b1;
         end else if (s_q.tick_q) begin
            s_d.sflag_q[i] = 1'b0;
         end
         if (ev[i]) begin
            s_d.pcnt_q[i] = PULSE_W'(PIN_PULSE_CYC);
         end else if (s_q.pcnt_q[i] != '0) begin
            s_d.pcnt_q[i] = s_q.pcnt_q[i] - 1'b1;
         end
         pulsing[i]        = (s_d.pcnt_q[i] != '0);
         s_d.flag_out_q[i] = hold_mode[i] ? s_d.lat_q[i] : s_d.sflag_q[i];
      end

      // Pin B carries only the tilt event; its motion route bit stays zero.
      s_d.pin_a_q = mtd_pin_level(route_a, hold_mode, s_d.lat_q, pulsing);
      s_d.pin_b_q = mtd_pin_level(route_b, hold_mode, s_d.lat_q, pulsing);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q       <= '0;
         s_q.thr_q <= SIGMOVE_THR_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign thr_rdata_o          = s_q.thr_rdata_q;
   assign sigmove_event_flag_o = s_q.flag_out_q[EV_SIGMOVE];
   assign incline_event_flag_o = s_q.flag_out_q[EV_INCLINE];
   assign irq_pin_a_o          = s_q.pin_a_q;
   assign irq_pin_b_o          = s_q.pin_b_q;

endmodule : mtd_event_detector

/* design/mtd_pkg.sv */
/*
 * Constants shared by the motion and tilt event detector: timing, reset
 * values and the tilt angle comparison ratio.
 * Assumes a 50 MHz system clock and a 26 Hz embedded evaluation rate.
 */
package mtd_pkg;

   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned EVAL_RATE_HZ    = 26;
   localparam int unsigned EVAL_PERIOD_CYC = CLK_HZ / EVAL_RATE_HZ;
   localparam int unsigned TICK_W          = 21;

   // Pin pulse length in its own unit, then in whole clock cycles.
   localparam int unsigned PIN_PULSE_NS  = 75_000;
   localparam int unsigned PIN_PULSE_CYC = (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PULSE_W       = 12;

   // First tilt event needs the excess angle held this long.
   localparam int unsigned TILT_HOLD_S     = 2;
   localparam int unsigned TILT_HOLD_TICKS = TILT_HOLD_S * EVAL_RATE_HZ;
   localparam int unsigned HOLD_W          = 6;

   // Threshold register reset value and width.
   localparam logic [7:0] SIGMOVE_THR_RESET = 8'h06;

   // Tilt limit of 35 degrees: cos^2(35 deg) approximated as 687/1024.
   localparam int unsigned TILT_ANGLE_DEG = 35;
   localparam int unsigned COS2_NUM       = 687;
   localparam int unsigned COS2_SHIFT     = 10;

   // Event indices.
   localparam int unsigned EV_SIGMOVE = 0;
   localparam int unsigned EV_INCLINE = 1;
   localparam int unsigned EV_N       = 2;

endpackage : mtd_pkg

/* sim/mtd_checker.sv */
/* Assertions on the event detector ports.
   Assumes it is bound to the detector and sees only its ports. */
module mtd_checker
#(
   parameter int TICK_CYCLES = 20
) (
   // Clock and reset.
   input wire logic       mclk_i,
   input wire logic       rst_b_i,
   // Controls.
   input wire logic       embedded_functions_on_i,
   input wire logic       sigmove_enable_i,
   input wire logic       incline_enable_i,
   input wire logic       latch_events_i,
   input wire logic       sigmove_route_pin_a_i,
   input wire logic       incline_route_pin_a_i,
   input wire logic       incline_route_pin_b_i,
   input wire logic       bank_access_bit_i,
   input wire logic       thr_wr_i,
   input wire logic [7:0] thr_wdata_i,
   input wire logic       event_src_rd_i,
   input wire logic       step_detected_i,
   // Outputs.
   input wire logic [7:0] thr_rdata_o,
   input wire logic       sigmove_event_flag_o,
   input wire logic       incline_event_flag_o,
   input wire logic       irq_pin_a_o,
   input wire logic       irq_pin_b_o
);
   localparam int FLAG_MAX = TICK_CYCLES + 2;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_held;
      latch_events_i && sigmove_route_pin_a_i && sigmove_event_flag_o && !event_src_rd_i
      ##1 latch_events_i && sigmove_route_pin_a_i;
   endsequence
   wr_echo_a: assert property (bank_access_bit_i && thr_wr_i |=> thr_rdata_o == $past(thr_wdata_i))
      else $error("threshold write not echoed");
   closed_zero_a: assert property (!bank_access_bit_i |=> thr_rdata_o == 8'h00)
      else $error("closed bank read not zero");
   sm_cause_a: assert property ($rose(sigmove_event_flag_o) |->
      $past(embedded_functions_on_i && sigmove_enable_i && step_detected_i)
      || $past(embedded_functions_on_i && sigmove_enable_i && step_detected_i, 2))
      else $error("motion flag without enabled step");
   tilt_gate_a: assert property ($rose(incline_event_flag_o) |->
      $past(embedded_functions_on_i && incline_enable_i)) else $error("tilt flag while disabled");
   pin_a_route_a: assert property ($rose(irq_pin_a_o) |->
      $past(sigmove_route_pin_a_i || incline_route_pin_a_i)) else $error("pin A unrouted");
   pin_b_route_a: assert property ($rose(irq_pin_b_o) |->
      $past(incline_route_pin_b_i) && incline_event_flag_o) else $error("pin B unrouted");
   pin_hold_a: assert property ($rose(irq_pin_a_o) && !latch_events_i |-> irq_pin_a_o[*8])
      else $error("pin pulse too short");
   flag_pulse_a: assert property ($rose(sigmove_event_flag_o) &&
      (!latch_events_i || !sigmove_route_pin_a_i) |-> ##[1:FLAG_MAX] !sigmove_event_flag_o)
      else $error("motion flag not pulsed");
   latch_hold_a: assert property (s_held |-> sigmove_event_flag_o)
      else $error("latched flag dropped");
   latch_clear_a: assert property (event_src_rd_i && latch_events_i && sigmove_route_pin_a_i && !step_detected_i
      |-> ##[1:2] !sigmove_event_flag_o) else $error("latched flag not cleared");
endmodule : mtd_checker

bind mtd_event_detector mtd_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

/* sim/mtd_event_detector_test.sv */
/* Self-checking bench for the motion and tilt event detector.
   Assumes a 50 MHz clock and an evaluation tick shortened to 20 cycles. */
module mtd_event_detector_test
   import mtd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TK = 20;
   logic mclk_i = 0, rst_b_i = 0, embedded_functions_on_i = 0, sigmove_enable_i = 0, incline_enable_i = 0;
   logic latch_events_i = 0, sigmove_route_pin_a_i = 0, incline_route_pin_a_i = 0, incline_route_pin_b_i = 0;
   logic bank_access_bit_i = 0, thr_wr_i = 0, step_detected_i = 0, debounce_active_i = 0, svc_en = 0;
   logic [7:0] thr_wdata_i = 8'h00, thr_rdata_o;
   logic [2:0] debounce_step_count_i = 3'h0;
   logic [15:0] acc_x_i = 16'h0000, acc_y_i = 16'h0000, acc_z_i = 16'h03e8;
   logic event_src_rd_i, sigmove_event_flag_o, incline_event_flag_o, irq_pin_a_o, irq_pin_b_o;
   logic [3:0] obs;
   int error_cnt = 0;
   int cmp_count = 0;
   assign obs = {irq_pin_b_o, irq_pin_a_o, incline_event_flag_o, sigmove_event_flag_o};
   always #10 mclk_i = ~mclk_i;
   mtd_event_detector #(.ACC_W(16), .TICK_CYCLES(TK)) DUT (.*);
   mtd_host_model host (.mclk_i, .rst_b_i, .irq_pin_a_o, .irq_pin_b_o, .svc_en_i(svc_en),
      .svc_delay_i(8'h1e), .event_src_rd_o(event_src_rd_i));
   task automatic print_verdict();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wait_for(input int sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while (obs[sel] !== lvl) begin
         if (n == lim) begin
            error_cnt++;
            print_verdict();
         end
         cyc(1);
         n++;
      end
      cmp_count++;
   endtask : wait_for
   task automatic step(input int n);
      repeat (n) begin
         step_detected_i = 1;
         cyc(1);
         step_detected_i = 0;
         cyc(1);
      end
   endtask : step
   task automatic thr_write(input logic [7:0] v);
      thr_wr_i = 1;
      thr_wdata_i = v;
      cyc(1);
      thr_wr_i = 0;
      cyc(1);
   endtask : thr_write
   task automatic t_reg();
      bank_access_bit_i = 1;
      cyc(2);
      chk("thr reset", thr_rdata_o, 8'h06);
      thr_write(8'hff);
      chk("thr max", thr_rdata_o, 8'hff);
      thr_write(8'h02);
      bank_access_bit_i = 0;
      cyc(2);
      chk("thr closed", thr_rdata_o, 8'h00);
      thr_write(8'h09);
      bank_access_bit_i = 1;
      cyc(2);
      chk("thr refused", thr_rdata_o, 8'h02);
      bank_access_bit_i = 0;
   endtask : t_reg
   task automatic t_sig();
      embedded_functions_on_i = 1;
      sigmove_enable_i = 1;
      sigmove_route_pin_a_i = 1;
      step(1);
      chk("one step", sigmove_event_flag_o, 0);
      step(1);
      wait_for(0, 1, 4);
      chk("pin a", irq_pin_a_o, 1);
      wait_for(0, 0, TK + 2);
      chk("pin stays", irq_pin_a_o, 1);
      cyc(PIN_PULSE_CYC);
      chk("pin ends", irq_pin_a_o, 0);
      step(1);
      chk("restart", sigmove_event_flag_o, 0);
      step(1);
      wait_for(0, 1, 4);
      cyc(TK + 2);
      sigmove_enable_i = 0;
      step(3);
      chk("disabled", sigmove_event_flag_o, 0);
      sigmove_enable_i = 1;
      debounce_active_i = 1;
      debounce_step_count_i = 3'h4;
      step(3);
      chk("debounce", sigmove_event_flag_o, 0);
      step(1);
      wait_for(0, 1, 4);
      debounce_active_i = 0;
      cyc(PIN_PULSE_CYC);
   endtask : t_sig
   task automatic t_latch();
      latch_events_i = 1;
      svc_en = 1;
      step(2);
      wait_for(0, 1, 4);
      cyc(TK + 2);
      chk("latched", sigmove_event_flag_o, 1);
      wait_for(2, 0, 60);
      chk("cleared", sigmove_event_flag_o, 0);
      sigmove_route_pin_a_i = 0;
      step(2);
      wait_for(0, 1, 4);
      wait_for(0, 0, TK + 2);
      chk("unrouted", irq_pin_a_o, 0);
      sigmove_enable_i = 0;
      latch_events_i = 0;
   endtask : t_latch
   task automatic t_tilt();
      incline_route_pin_b_i = 1;
      incline_enable_i = 1;
      cyc(2);
      acc_y_i = 16'h012c;
      cyc(60 * TK);
      chk("small tilt", incline_event_flag_o, 0);
      acc_y_i = 16'h0000;
      acc_x_i = 16'h03e8;
      acc_z_i = 16'h0000;
      cyc(40 * TK);
      chk("tilt early", incline_event_flag_o, 0);
      wait_for(1, 1, 16 * TK);
      chk("tilt pin b", irq_pin_b_o, 1);
      chk("tilt pin a", irq_pin_a_o, 0);
      wait_for(1, 0, TK + 2);
      incline_route_pin_a_i = 1;
      acc_x_i = 16'h0000;
      acc_z_i = 16'h03e8;
      wait_for(1, 1, 2 * TK + 2);
      chk("tilt both", irq_pin_a_o, 1);
   endtask : t_tilt
   initial begin
      cyc(12);
      rst_b_i = 1;
      cyc(2);
      t_reg();
      t_sig();
      t_latch();
      t_tilt();
      print_verdict();
   end
endmodule : mtd_event_detector_test

/* sim/mtd_host_model.sv */
/* Host model that services the pins by reading the event source register.
   Assumes active-high pins on the detector clock. */
module mtd_host_model (
   // Clock and reset.
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // Pins and service setup.
   input  wire logic       irq_pin_a_o,
   input  wire logic       irq_pin_b_o,
   input  wire logic       svc_en_i,
   input  wire logic [7:0] svc_delay_i,
   output logic            event_src_rd_o
);
   logic [7:0] wait_q;
   // A slow host lets a latched pin stand long enough to be seen.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_q         <= 8'h00;
         event_src_rd_o <= 1'b0;
      end else begin
         event_src_rd_o <= 1'b0;
         if (svc_en_i && (irq_pin_a_o || irq_pin_b_o) && !event_src_rd_o) begin
            wait_q <= wait_q + 8'h01;
            if (wait_q == svc_delay_i) begin
               wait_q         <= 8'h00;
               event_src_rd_o <= 1'b1;
            end
         end
      end
   end
endmodule : mtd_host_model
